// >>> rtl/ntb_lnk_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the link regs
// Assumes: Included by its bare name from every file that needs it
// Notes: Definitions only
`ifndef NTB_LNK_CFG_SVH
`define NTB_LNK_CFG_SVH

// Register byte offsets in configuration space
`define NTB_LCAP_OFF 12'h04C
`define NTB_LCTL_OFF 12'h050

// Capability field positions
`define NTB_SPD_LSB 0
`define NTB_SPD_MSB 3
`define NTB_WID_LSB 4
`define NTB_WID_MSB 9
`define NTB_PMS_LSB 10
`define NTB_PMS_MSB 11
`define NTB_L0S_LSB 12
`define NTB_L0S_MSB 14
`define NTB_L1_LSB 15
`define NTB_L1_MSB 17
`define NTB_PORT_LSB 24
`define NTB_PORT_MSB 31

// Control field positions
`define NTB_PMC_LSB 0
`define NTB_PMC_MSB 1
`define NTB_RCB_BIT 3
`define NTB_LINK_DISABLE_BIT_BIT 4
`define NTB_RET_BIT 5
`define NTB_COMMON_CLOCK_BIT_BIT 6
`define NTB_EXTENDED_SYNC_BIT_BIT 7

// Fixed and reset values
`define NTB_SPD_VAL 4'h1
`define NTB_WID_RST 6'h04
`define NTB_WID_X1 6'h01
`define NTB_WID_X2 6'h02
`define NTB_WID_X4 6'h04
`define NTB_PMS_VAL 2'h1
`define NTB_L0S_SEP 3'h5
`define NTB_L0S_COM 3'h3
`define NTB_L1_DEEP 3'h0
`define NTB_L1_DFLT 3'h4
`define NTB_PORT_RST 8'h02
`define NTB_PMC_RST 2'h0

// Ordered-set counts on L0s exit
`define NTB_EXTENDED_SYNC_BIT_FTS 13'h1000
`define NTB_NORM_FTS 13'h0020

`endif

// >>> rtl/ntb_lnk_pkg.sv
// Purpose: Types shared by the link register block and its exit sequencer
// Assumes: Constants live in ntb_lnk_cfg.svh
// Notes: State of each module is one packed struct
package ntb_lnk_pkg;

    // Exit sequencer states
    typedef enum logic [1:0] {
        NTB_SEQ_IDLE = 2'b00,
        NTB_SEQ_FTS = 2'b01,
        NTB_SEQ_SKP = 2'b10
    } ntb_seq_st_t;

    // Exit sequencer state
    typedef struct packed {
        ntb_seq_st_t st;
        logic [12:0] cnt;
        logic fts;
        logic skp;
        logic busy;
    } ntb_seq_t;

    // Register block state
    typedef struct packed {
        logic [1:0] pm_ctl;
        logic link_disable_bit;
        logic common_clock_bit;
        logic extended_sync_bit;
        logic [5:0] width;
        logic [7:0] port_num;
        logic retrain;
        logic [31:0] rdata;
        logic rvalid;
        logic [5:0] eff_width;
        logic l0s_en;
        logic l1_en;
    } ntb_regs_t;

endpackage

// >>> rtl/ntb_lnk_seq_if.sv
// Purpose: Carries L0s exit requests and ordered-set strobes
// Assumes: Single clock domain
// Notes: ctl side is the register block, seq side the sequencer
`timescale 1ns/1ps
`default_nettype none
interface ntb_lnk_seq_if;
    logic start;
    logic extended_sync_bit;
    logic os_ready;
    logic fts;
    logic skp;
    logic busy;

    modport ctl (output start, output extended_sync_bit, output os_ready,
                 input fts, input skp, input busy);
    modport seq (input start, input extended_sync_bit, input os_ready,
                 output fts, output skp, output busy);
endinterface
`default_nettype wire

// >>> rtl/ntb_lnk_seq.sv
// Purpose: Sends the FTS burst, and SKP under extended sync, on L0s exit
// Assumes: One ordered set is taken per cycle while os_ready is high
// Notes: A start while busy is ignored
`include "ntb_lnk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ntb_lnk_seq
    import ntb_lnk_pkg::*;
#(
    parameter logic [12:0] EXTENDED_SYNC_BIT_FTS = `NTB_EXTENDED_SYNC_BIT_FTS,
    parameter logic [12:0] NORM_FTS = `NTB_NORM_FTS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link to register block
    ntb_lnk_seq_if.seq sq
);

    ntb_seq_t s_ff;
    ntb_seq_t nxt_s;

    assign sq.fts = s_ff.fts;
    assign sq.skp = s_ff.skp;
    assign sq.busy = s_ff.busy;

    // Next-state logic
    always_comb begin
        nxt_s = s_ff;
        nxt_s.fts = 1'b0;
        nxt_s.skp = 1'b0;
        case (s_ff.st)
            NTB_SEQ_IDLE: begin
                if (sq.start) begin
                    nxt_s.st = NTB_SEQ_FTS;
                    nxt_s.cnt = sq.extended_sync_bit ? EXTENDED_SYNC_BIT_FTS : NORM_FTS;
                    nxt_s.busy = 1'b1;
                end
            end
            NTB_SEQ_FTS: begin
                if (sq.os_ready) begin
                    nxt_s.fts = 1'b1;
                    nxt_s.cnt = s_ff.cnt - 13'h0001;
                    if (s_ff.cnt == 13'h0001) begin
                        // One SKP follows only under extended sync
                        if (sq.extended_sync_bit) begin
                            nxt_s.st = NTB_SEQ_SKP;
                        end else begin
                            nxt_s.st = NTB_SEQ_IDLE;
                            nxt_s.busy = 1'b0;
                        end
                    end
                end
            end
            NTB_SEQ_SKP: begin
                if (sq.os_ready) begin
                    nxt_s.skp = 1'b1;
                    nxt_s.st = NTB_SEQ_IDLE;
                    nxt_s.busy = 1'b0;
                end
            end
            default: begin
                nxt_s.st = NTB_SEQ_IDLE;
                nxt_s.busy = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '{st: NTB_SEQ_IDLE, cnt: 13'h0000, fts: 1'b0, skp: 1'b0, busy: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/ntb_lnk_regs.sv
// Purpose: Link capability and link control registers of the NTB port
// Assumes: Config space access is one dword per request with byte enables
//          All inputs synchronous to clk_i; reset is synchronous
// Notes: Read data valid one cycle after the read strobe
//        Capability writes land only while lockable_write_i is high
//        A control write and a serial memory load in one cycle: the write wins
//        Link disable is stored for software only and drives nothing
//        Width codes outside 1, 2 and 4 fall back to one lane in eff_width_o
//        Burst counts are parameters so a bench can shorten them
`include "ntb_lnk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ntb_lnk_regs
    import ntb_lnk_pkg::*;
#(
    parameter logic [12:0] EXTENDED_SYNC_BIT_FTS = `NTB_EXTENDED_SYNC_BIT_FTS,
    parameter logic [12:0] NORM_FTS = `NTB_NORM_FTS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration space access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // Write lock and deep power mode settings
    input wire logic lockable_write_i,
    input wire logic deep_d3_disable_i,
    input wire logic deep_l1_disable_i,
    // Serial memory start-up load
    input wire logic eeprom_pm_load_i,
    input wire logic [1:0] eeprom_pm_data_i,
    // Training and power control
    output logic retrain_req_o,
    output logic l0s_entry_en_o,
    output logic l1_entry_en_o,
    output logic common_clock_o,
    output logic [5:0] eff_width_o,
    // L0s exit ordered sets
    input wire logic l0s_exit_i,
    input wire logic os_ready_i,
    output logic fts_send_o,
    output logic skp_send_o,
    output logic exit_busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // State and sequencer

    // Whole register state and its next value
    ntb_regs_t r_ff;
    ntb_regs_t nxt_r;
    // Link to the ordered-set sequencer
    ntb_lnk_seq_if sq ();

    // Assembled read words and byte mask
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [31:0] wmask;
    // Address decode results
    logic hit_cap;
    logic hit_ctl;
    // Latency codes and merged width
    logic [2:0] l0s_code;
    logic [2:0] l1_code;
    logic [5:0] new_width;

    // Address map: each register sits in a dword of its own; the control
    // register is 16 bits wide, so the upper half of its dword reads zero
    localparam logic [11:0] CAP_OFF = `NTB_LCAP_OFF;
    localparam logic [11:0] CTL_OFF = `NTB_LCTL_OFF;
    localparam logic [9:0] CAP_DW = CAP_OFF[11:2];
    localparam logic [9:0] CTL_DW = CTL_OFF[11:2];

    // The sequencer samples extended_sync_bit on every cycle, so a control write in the
    // middle of a burst still decides whether the SKP follows
    // Exit requests go straight to the sequencer
    assign sq.start = l0s_exit_i;
    assign sq.extended_sync_bit = r_ff.extended_sync_bit;
    assign sq.os_ready = os_ready_i;

    // Ordered-set sequencer; a start while busy is dropped inside it
    // Same burst counts as this block's parameters
    ntb_lnk_seq #(
        .EXTENDED_SYNC_BIT_FTS(EXTENDED_SYNC_BIT_FTS),
        .NORM_FTS(NORM_FTS)
    ) u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sq(sq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read words

    // Both latency codes are live: a change of the common clock bit or of a
    // deep disable input shows at the next read
    // No state here, so the codes cannot go stale
    // Latency codes from clocking and deep modes
    always_comb begin
        l0s_code = r_ff.common_clock_bit ? `NTB_L0S_COM : `NTB_L0S_SEP;
        if (deep_d3_disable_i || deep_l1_disable_i) begin
            l1_code = `NTB_L1_DEEP;
        end else begin
            l1_code = `NTB_L1_DFLT;
        end
    end

    // Speed and PM support are constants; port and width are lockable fields
    // Capability word, reserved bits zero
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[`NTB_SPD_MSB:`NTB_SPD_LSB] = `NTB_SPD_VAL;
        cap_word[`NTB_WID_MSB:`NTB_WID_LSB] = r_ff.width;
        cap_word[`NTB_PMS_MSB:`NTB_PMS_LSB] = `NTB_PMS_VAL;
        cap_word[`NTB_L0S_MSB:`NTB_L0S_LSB] = l0s_code;
        cap_word[`NTB_L1_MSB:`NTB_L1_LSB] = l1_code;
        cap_word[`NTB_PORT_MSB:`NTB_PORT_LSB] = r_ff.port_num;
    end

    // Link disable reads back what was written
    // Control word; boundary and retrain bits read zero
    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[`NTB_PMC_MSB:`NTB_PMC_LSB] = r_ff.pm_ctl;
        ctl_word[`NTB_LINK_DISABLE_BIT_BIT] = r_ff.link_disable_bit;
        ctl_word[`NTB_COMMON_CLOCK_BIT_BIT] = r_ff.common_clock_bit;
        ctl_word[`NTB_EXTENDED_SYNC_BIT_BIT] = r_ff.extended_sync_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode and write mask

    // Only bits 11:2 are compared; byte lanes come from the enables
    // Any other dword reads zero and ignores writes
    // Dword address match
    always_comb begin
        hit_cap = 1'b0;
        hit_ctl = 1'b0;
        if (cfg_addr_i[11:2] == CAP_DW) begin
            hit_cap = 1'b1;
        end else if (cfg_addr_i[11:2] == CTL_DW) begin
            hit_ctl = 1'b1;
        end
    end

    // Spread so that one AND selects the written bits of any field
    // Byte enables spread to bits
    always_comb begin
        wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
    end

    // Bits 7:4 follow byte enable 0 and bits 9:8 byte enable 1
    // Masked width merge
    always_comb begin
        new_width = (r_ff.width & ~wmask[`NTB_WID_MSB:`NTB_WID_LSB])
                  | (cfg_wdata_i[`NTB_WID_MSB:`NTB_WID_LSB]
                     & wmask[`NTB_WID_MSB:`NTB_WID_LSB]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Register next values; one-cycle pulses fall back to zero here
    // The serial memory load sits above the config write, so a write in
    // the same cycle overrides it
    // Decoded outputs are taken from the next value to stay in step
    always_comb begin
        nxt_r = r_ff;
        nxt_r.retrain = 1'b0;
        nxt_r.rvalid = 1'b0;

        // Start-up load of PM control
        if (eeprom_pm_load_i) begin
            nxt_r.pm_ctl = eeprom_pm_data_i;
        end

        // Capability writes: only lockable fields
        // Width merges per byte enable, so a partial write keeps other bits
        // Port number needs the top byte enable
        if (cfg_wr_i && hit_cap && lockable_write_i) begin
            nxt_r.width = new_width;
            if (cfg_be_i[3]) begin
                nxt_r.port_num = cfg_wdata_i[`NTB_PORT_MSB:`NTB_PORT_LSB];
            end
        end

        // Control writes, low byte only holds fields
        // Retrain is a pulse and is never stored; readback is zero
        if (cfg_wr_i && hit_ctl && cfg_be_i[0]) begin
            nxt_r.pm_ctl = cfg_wdata_i[`NTB_PMC_MSB:`NTB_PMC_LSB];
            nxt_r.link_disable_bit = cfg_wdata_i[`NTB_LINK_DISABLE_BIT_BIT];
            nxt_r.common_clock_bit = cfg_wdata_i[`NTB_COMMON_CLOCK_BIT_BIT];
            nxt_r.extended_sync_bit = cfg_wdata_i[`NTB_EXTENDED_SYNC_BIT_BIT];
            nxt_r.retrain = cfg_wdata_i[`NTB_RET_BIT];
        end

        // Read data, zero for unmapped addresses
        // Read and write in one cycle: the read returns the old contents
        // Unmapped reads still answer, with zero data
        if (cfg_rd_i) begin
            nxt_r.rvalid = 1'b1;
            if (hit_cap) begin
                nxt_r.rdata = cap_word;
            end else if (hit_ctl) begin
                nxt_r.rdata = ctl_word;
            end else begin
                nxt_r.rdata = 32'h0000_0000;
            end
        end

        // Effective width falls back to one lane
        // Looked at on the next value, so eff_width_o moves with the register
        if (nxt_r.width == `NTB_WID_X1 || nxt_r.width == `NTB_WID_X2
            || nxt_r.width == `NTB_WID_X4) begin
            nxt_r.eff_width = nxt_r.width;
        end else begin
            nxt_r.eff_width = `NTB_WID_X1;
        end

        // Entry enables decoded from PM control
        // Either source of PM control, write or load, reaches them
        nxt_r.l0s_en = nxt_r.pm_ctl[0];
        nxt_r.l1_en = nxt_r.pm_ctl[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Every field of the state struct is flopped here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Software fields
            r_ff.pm_ctl <= `NTB_PMC_RST;
            r_ff.link_disable_bit <= 1'b0;
            r_ff.common_clock_bit <= 1'b0;
            r_ff.extended_sync_bit <= 1'b0;
            r_ff.width <= `NTB_WID_RST;
            r_ff.port_num <= `NTB_PORT_RST;

            // Pulses and read path
            r_ff.retrain <= 1'b0;
            r_ff.rdata <= 32'h0000_0000;
            r_ff.rvalid <= 1'b0;

            // Decoded outputs, in step with the fields above
            // Reset width is a legal code, so no fallback applies
            r_ff.eff_width <= `NTB_WID_RST;
            r_ff.l0s_en <= 1'b0;
            r_ff.l1_en <= 1'b0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Config read answer
    assign cfg_rdata_o = r_ff.rdata;
    assign cfg_rvalid_o = r_ff.rvalid;

    // Training and power control
    assign retrain_req_o = r_ff.retrain;
    assign l0s_entry_en_o = r_ff.l0s_en;
    assign l1_entry_en_o = r_ff.l1_en;
    assign common_clock_o = r_ff.common_clock_bit;
    assign eff_width_o = r_ff.eff_width;

    // Ordered-set strobes, straight from the sequencer registers
    assign fts_send_o = sq.fts;
    assign skp_send_o = sq.skp;
    assign exit_busy_o = sq.busy;

endmodule
`default_nettype wire

// >>> tb/ntb_lnk_regs_asserts.sv
// Purpose: Port-level checks of the link capability and control registers
// Assumes: Sees only the ports of ntb_lnk_regs; one clock domain
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module ntb_lnk_regs_asserts #(
    parameter logic [12:0] EXTENDED_SYNC_BIT_FTS = 13'h1000,
    parameter logic [12:0] NORM_FTS = 13'h0020
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    // Settings and outputs
    input wire logic deep_d3_disable_i,
    input wire logic deep_l1_disable_i,
    input wire logic retrain_req_o,
    input wire logic l0s_entry_en_o,
    input wire logic l1_entry_en_o,
    input wire logic common_clock_o,
    input wire logic l0s_exit_i,
    input wire logic fts_send_o,
    input wire logic skp_send_o,
    input wire logic exit_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////
    logic cap_ff;
    logic ctl_ff;
    logic ret_ff;
    logic rv_cap;
    logic rv_ctl;
    logic deep;
    logic [12:0] fts_cnt;

    // FTS pulses counted over one busy stretch of the sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i || !exit_busy_o) begin
            fts_cnt <= 13'h0000;
        end else if (fts_send_o) begin
            fts_cnt <= fts_cnt + 13'h0001;
        end
    end

    // Remember which register a read or retrain write targeted
    always_ff @(posedge clk_i) begin
        cap_ff <= !rst_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h013;
        ctl_ff <= !rst_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h014;
        ret_ff <= !rst_i && cfg_wr_i && cfg_addr_i[11:2] == 10'h014
            && cfg_be_i[0] && cfg_wdata_i[5];
    end

    // Read answers per register
    assign rv_cap = cfg_rvalid_o && cap_ff;
    assign rv_ctl = cfg_rvalid_o && ctl_ff;
    assign deep = deep_d3_disable_i | deep_l1_disable_i;

    ////////////////////////////////////////////////////////////////////
    a_speed_fixed: assert property (rv_cap |-> cfg_rdata_o[3:0] == 4'h1)
        else $error("max speed code wrong");
    a_pm_support: assert property (rv_cap |-> cfg_rdata_o[11:10] == 2'h1)
        else $error("pm support code wrong");
    a_l0s_latency: assert property (rv_cap && $stable(common_clock_o) |->
        cfg_rdata_o[14:12] == (common_clock_o ? 3'h3 : 3'h5))
        else $error("l0s exit latency code wrong");
    a_l1_latency: assert property (rv_cap && $stable(deep) |->
        cfg_rdata_o[17:15] == (deep ? 3'h0 : 3'h4))
        else $error("l1 exit latency code wrong");
    a_cap_reserved: assert property (rv_cap |-> cfg_rdata_o[23:18] == 6'h00)
        else $error("capability reserved bits set");
    a_ctl_fixed: assert property (rv_ctl |-> cfg_rdata_o[31:8] == 24'h0
        && cfg_rdata_o[5] == 1'b0 && cfg_rdata_o[3:2] == 2'h0)
        else $error("control fixed bits not zero");
    a_pm_readback: assert property (rv_ctl && $stable({l1_entry_en_o, l0s_entry_en_o})
        |-> cfg_rdata_o[1:0] == {l1_entry_en_o, l0s_entry_en_o})
        else $error("pm control readback differs from enables");
    a_common_clock_bit_readback: assert property (rv_ctl && $stable(common_clock_o)
        |-> cfg_rdata_o[6] == common_clock_o)
        else $error("common clock readback differs");
    a_retrain_pulse: assert property (retrain_req_o == ret_ff)
        else $error("retrain request not tied to retrain write");
    a_exit_start: assert property (l0s_exit_i && !exit_busy_o |=> exit_busy_o)
        else $error("exit sequence did not start");
    a_one_set: assert property (!(fts_send_o && skp_send_o))
        else $error("two ordered sets in one cycle");
    a_skp_after_fts: assert property (skp_send_o |-> fts_cnt == EXTENDED_SYNC_BIT_FTS)
        else $error("skip set sent before the full fast-training burst");
    a_norm_fts_count: assert property ($fell(exit_busy_o) && !skp_send_o
        && !$past(rst_i) |-> fts_cnt + 13'h0001 == NORM_FTS)
        else $error("normal exit burst length wrong");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the link capability and control registers
// Assumes: Inputs change at the falling edge of clk_i
// Notes: Ordered-set counts shortened to 4 and 2
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [12:0] ESF = 13'h0004;
    localparam logic [12:0] NF = 13'h0002;
    logic clk_i, rst_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o, lockable_write_i;
    logic deep_d3_disable_i, deep_l1_disable_i, eeprom_pm_load_i, retrain_req_o;
    logic l0s_entry_en_o, l1_entry_en_o, common_clock_o, l0s_exit_i, os_ready_i;
    logic fts_send_o, skp_send_o, exit_busy_o;
    logic [11:0] cfg_addr_i;
    logic [3:0] cfg_be_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, rv;
    logic [1:0] eeprom_pm_data_i;
    logic [5:0] eff_width_o;
    int bad_count = 0;
    int n_tests = 0;

    // Block under test
    ntb_lnk_regs #(.EXTENDED_SYNC_BIT_FTS(ESF), .NORM_FTS(NF)) dut_u (.*);

    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    function automatic logic [31:0] cap(input logic [7:0] p, input logic [5:0] w,
        input logic cc, input logic dp);
        return {p, 6'h00, dp ? 3'h0 : 3'h4, cc ? 3'h3 : 3'h5, 2'h1, w, 4'h1};
    endfunction

    // One write; checks the retrain pulse in the following cycle
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_be_i = be;
        cfg_wdata_i = d;
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
        chk({31'h0, a == 12'h050 && be[0] && d[5]}, {31'h0, retrain_req_o});
        @(negedge clk_i);
    endtask

    // One read; data captured in rv
    task automatic rd(input logic [11:0] a);
        cfg_rd_i = 1'b1;
        cfg_addr_i = a;
        @(negedge clk_i);
        cfg_rd_i = 1'b0;
        chk(32'h1, {31'h0, cfg_rvalid_o});
        rv = cfg_rdata_o;
        @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(12'h04C);
        chk(cap(8'h02, 6'h04, 1'b0, 1'b0), rv);
        rd(12'h050);
        chk(32'h0, rv);
        rd(12'h054);
        chk(32'h0, rv);
        chk(32'h4, {26'h0, eff_width_o});
    endtask

    task automatic t_cap_lock;
        wr(12'h04C, 4'hF, 32'hFFFF_FFFF);
        rd(12'h04C);
        chk(cap(8'h02, 6'h04, 1'b0, 1'b0), rv);
        lockable_write_i = 1'b1;
        wr(12'h04C, 4'hF, 32'hFFFF_FFFF);
        rd(12'h04C);
        chk(cap(8'hFF, 6'h3F, 1'b0, 1'b0), rv);
        chk(32'h1, {26'h0, eff_width_o});
        for (int i = 0; i < 6; i++) begin
            wr(12'h04C, 4'h3, {22'h0, i[5:0], 4'h0});
            chk((i == 1 || i == 2 || i == 4) ? i : 1, {26'h0, eff_width_o});
        end
        wr(12'h04C, 4'hF, 32'h0200_0040);
        lockable_write_i = 1'b0;
    endtask

    task automatic t_ctl;
        wr(12'h050, 4'hF, 32'hFFFF_FFFF);
        rd(12'h050);
        chk(32'h0000_00D3, rv);
        chk(32'h7, {29'h0, common_clock_o, l1_entry_en_o, l0s_entry_en_o});
        rd(12'h04C);
        chk(cap(8'h02, 6'h04, 1'b1, 1'b0), rv);
        for (int i = 0; i < 4; i++) begin
            wr(12'h050, 4'h1, i);
            chk(i, {30'h0, l1_entry_en_o, l0s_entry_en_o});
        end
    endtask

    task automatic t_deep;
        for (int i = 1; i < 5; i++) begin
            {deep_l1_disable_i, deep_d3_disable_i} = i[1:0];
            @(negedge clk_i);
            rd(12'h04C);
            chk(cap(8'h02, 6'h04, 1'b0, i[1:0] != 2'h0), rv);
        end
    endtask

    task automatic t_eeprom;
        eeprom_pm_data_i = 2'h2;
        eeprom_pm_load_i = 1'b1;
        @(negedge clk_i);
        eeprom_pm_load_i = 1'b0;
        @(negedge clk_i);
        chk(32'h2, {30'h0, l1_entry_en_o, l0s_entry_en_o});
        rd(12'h050);
        chk(32'h2, rv);
    endtask

    // Exit burst with a stalling sink and a start while busy
    task automatic t_exit(input logic es, input int nf, input int ns);
        int f = 0;
        int s = 0;
        wr(12'h050, 4'h1, {24'h0, es, 7'h0});
        l0s_exit_i = 1'b1;
        @(negedge clk_i);
        l0s_exit_i = 1'b0;
        chk(32'h1, {31'h0, exit_busy_o});
        for (int k = 0; k < 100; k++) begin
            @(negedge clk_i);
            os_ready_i = ~os_ready_i;
            l0s_exit_i = (k == 1);
            f += (fts_send_o === 1'b1);
            s += (skp_send_o === 1'b1);
            if (exit_busy_o !== 1'b1) break;
        end
        chk(nf, f);
        chk(ns, s);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Main sequence
    initial begin
        {rst_i, os_ready_i} = 2'b11;
        {cfg_wr_i, cfg_rd_i, lockable_write_i, l0s_exit_i} = 4'h0;
        {deep_d3_disable_i, deep_l1_disable_i, eeprom_pm_load_i} = 3'h0;
        {cfg_addr_i, cfg_be_i, cfg_wdata_i, eeprom_pm_data_i} = '0;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_cap_lock();
        t_ctl();
        t_deep();
        t_eeprom();
        t_exit(1'b1, ESF, 1);
        t_exit(1'b0, NF, 0);
        final_report();
    end

    // Watchdog
    initial begin
        #25000;
        bad_count++;
        final_report();
    end
endmodule

bind ntb_lnk_regs ntb_lnk_regs_asserts #(.EXTENDED_SYNC_BIT_FTS(EXTENDED_SYNC_BIT_FTS), .NORM_FTS(NORM_FTS)) chk_u (.*);
`default_nettype wire
